/* verilog/tsg_symbol_gen.sv */
// Transmit symbol generator: wraps a data frame with programmable symbols.
// Assumes frame bytes come from same-clock logic and tx_bit feeds the modulator.
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tsg_defs.svh"
module tsg_symbol_gen
  import tsg_pkg::*;
(
  input  wire logic                   clock,      // 40 MHz system clock
  input  wire logic                   reset_n,    // Async reset, active low
  input  wire logic [`TSG_ADDR_W-1:0] reg_addr,   // Register address
  input  wire logic [31:0]            reg_wdata,  // Write data
  input  wire logic                   reg_wr,     // Write strobe
  input  wire logic                   reg_rd,     // Read strobe
  output logic      [31:0]            reg_rdata,  // Read data, cycle after strobe
  input  wire logic                   frame_start,// Pulse: begin a frame
  input  wire logic                   data_valid, // Frame byte available
  input  wire logic [7:0]             data_byte,  // Frame byte
  input  wire logic                   data_last,  // Byte is the last of frame
  output logic                        data_ready, // Byte taken
  output logic                        tx_bit,     // Serial bit to modulator
  output logic                        tx_active,  // Frame in progress
  output logic                        tx_bit_stb, // Pulse at start of each bit
  output logic      [`TSG_CFG_W-1:0]  tx_cfg      // Active pair or data config
);

  // Register file
  logic [15:0] sym0_ff, sym1_ff;
  logic [7:0]  sym2_ff, sym3_ff;
  logic [7:0]  long_len_ff, short_len_ff;
  logic [7:0]  frame_con_ff;
  logic [`TSG_CFG_W-1:0] long_cfg_ff, short_cfg_ff;
  logic [25:0] burst_ff;
  logic [31:0] rdata_ff;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sym0_ff      <= 16'h0000;
      sym1_ff      <= 16'h0000;
      sym2_ff      <= 8'h00;
      sym3_ff      <= 8'h00;
      long_len_ff  <= 8'h00;
      short_len_ff <= 8'h00;
      frame_con_ff <= 8'h00;
      long_cfg_ff  <= `TSG_RST_CFG;
      short_cfg_ff <= `TSG_RST_CFG;
      burst_ff     <= 26'h0000000;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `TSG_A_SYM0:      sym0_ff      <= reg_wdata[15:0];
        `TSG_A_SYM1:      sym1_ff      <= reg_wdata[15:0];
        `TSG_A_SYM2:      sym2_ff      <= reg_wdata[7:0];
        `TSG_A_SYM3:      sym3_ff      <= reg_wdata[7:0];
        `TSG_A_LONG_LEN:  long_len_ff  <= reg_wdata[7:0];
        `TSG_A_SHORT_LEN: short_len_ff <= reg_wdata[7:0] & 8'h77;
        `TSG_A_FRAME_CON: frame_con_ff <= reg_wdata[7:0];
        `TSG_A_LONG_CFG:  long_cfg_ff  <= reg_wdata[`TSG_CFG_W-1:0];
        `TSG_A_SHORT_CFG: short_cfg_ff <= reg_wdata[`TSG_CFG_W-1:0];
        `TSG_A_BURST_LEN: burst_ff     <= reg_wdata[25:0];
        default: ;
      endcase
    end
  end

  // State of the serialiser
  tsg_state_t state_ff, nxt_state;
  logic [1:0]  sym_sel_ff;     // Symbol index in use
  logic [7:0]  bit_idx_ff;     // Bit counter within symbol, burst or byte
  logic [7:0]  div_ff;         // Bit clock divider
  logic [7:0]  byte_ff;        // Current data byte
  logic        last_ff;        // Current byte is last
  logic        tx_bit_ff;
  logic        busy_ff;
  logic        burst_post_ff;  // Running burst belongs to the trailing symbol

  // Read mux; unmapped addresses read zero
  wire [31:0] rd_mux =
    (reg_addr == `TSG_A_SYM0)      ? {16'h0000, sym0_ff} :
    (reg_addr == `TSG_A_SYM1)      ? {16'h0000, sym1_ff} :
    (reg_addr == `TSG_A_SYM2)      ? {24'h000000, sym2_ff} :
    (reg_addr == `TSG_A_SYM3)      ? {24'h000000, sym3_ff} :
    (reg_addr == `TSG_A_LONG_LEN)  ? {24'h000000, long_len_ff} :
    (reg_addr == `TSG_A_SHORT_LEN) ? {24'h000000, short_len_ff} :
    (reg_addr == `TSG_A_FRAME_CON) ? {24'h000000, frame_con_ff} :
    (reg_addr == `TSG_A_LONG_CFG)  ? {12'h000, long_cfg_ff} :
    (reg_addr == `TSG_A_SHORT_CFG) ? {12'h000, short_cfg_ff} :
    (reg_addr == `TSG_A_BURST_LEN) ? {6'h00, burst_ff} :
    (reg_addr == `TSG_A_STATUS)    ? {22'h000000, sym_sel_ff, 5'(state_ff), 3'(busy_ff)} :
    32'h00000000;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) rdata_ff <= 32'h00000000;
    else if (reg_rd) rdata_ff <= rd_mux;
  end
  assign reg_rdata = rdata_ff;

  // Symbol selection comes only from frame control fields
  wire [1:0] pre_field  = frame_con_ff[`TSG_FC_PRE_LO +: 2];
  wire [1:0] post_field = frame_con_ff[`TSG_FC_POST_LO +: 2];
  wire [3:0] dcode      = frame_con_ff[`TSG_FC_DCODE_LO +: 4];
  // 0 = none, 1..3 = sym0..sym2 before; sym1..sym3 after
  wire       pre_en     = (pre_field != 2'b00);
  wire [1:0] pre_sym    = pre_field - 2'b01;
  wire       post_en    = (post_field != 2'b00);
  wire [1:0] post_sym   = post_field;
  wire       data_en    = (dcode == `TSG_FC_DCODE_DEF);

  // Per-symbol length, pattern and pair config
  wire [3:0] len0 = long_len_ff[3:0];
  wire [3:0] len1 = long_len_ff[7:4];
  wire [3:0] len2 = {1'b0, short_len_ff[2:0]};
  wire [3:0] len3 = {1'b0, short_len_ff[6:4]};
  wire [3:0] cur_len = (sym_sel_ff == 2'd0) ? len0 : (sym_sel_ff == 2'd1) ? len1 :
                       (sym_sel_ff == 2'd2) ? len2 : len3;
  wire [15:0] cur_pat = (sym_sel_ff == 2'd0) ? sym0_ff : (sym_sel_ff == 2'd1) ? sym1_ff :
                        (sym_sel_ff == 2'd2) ? {8'h00, sym2_ff} : {8'h00, sym3_ff};
  wire [`TSG_CFG_W-1:0] pair_cfg = sym_sel_ff[1] ? short_cfg_ff : long_cfg_ff;
  wire        is_long   = ~sym_sel_ff[1];
  wire [7:0]  burst_n   = sym_sel_ff[0] ? burst_ff[23:16] : burst_ff[7:0];
  wire        burst_on  = is_long & (sym_sel_ff[0] ? burst_ff[24] : burst_ff[`TSG_BURST_EN]);
  wire        burst_lvl = sym_sel_ff[0] ? burst_ff[25] : burst_ff[`TSG_BURST_LVL];

  // Bit clock taken from the config in force for the current phase
  wire [`TSG_CFG_W-1:0] cur_cfg = (state_ff == TSG_DATA) ? long_cfg_ff : pair_cfg;
  wire [7:0] div_max  = cur_cfg[`TSG_CFG_DIV_W-1:0];
  wire       bit_end  = busy_ff & (div_ff == div_max);

  // Next bit value: pattern from bit[len] down, data LSB first
  wire [3:0] pidx = bit_idx_ff[3:0];
  wire       pat_bit  = cur_pat[pidx];
  wire       data_bit = byte_ff[bit_idx_ff[2:0]];

  // Phase sequencing; each phase's last bit rolls straight into the next
  logic [1:0] nxt_sel;
  logic [7:0] nxt_idx;
  logic       nxt_take;
  always_comb begin
    nxt_state = state_ff;
    nxt_sel   = sym_sel_ff;
    nxt_idx   = bit_idx_ff;
    nxt_take  = 1'b0;
    unique case (state_ff)
      TSG_IDLE: begin
        if (frame_start) begin
          if (pre_en) begin
            nxt_state = TSG_PRE;
            nxt_sel   = pre_sym;
          end else if (data_en) begin
            nxt_state = TSG_DATA;
            nxt_take  = 1'b1;
          end else if (post_en) begin
            nxt_state = TSG_POST;
            nxt_sel   = post_sym;
          end
        end
      end
      TSG_PRE, TSG_POST: begin
        if (bit_end) begin
          if (bit_idx_ff != 8'h00) nxt_idx = bit_idx_ff - 8'h01;
          else if (burst_on) begin
            nxt_state = TSG_BURST;
            nxt_idx   = burst_n;
          end else if (state_ff == TSG_PRE && data_en) begin
            nxt_state = TSG_DATA;
            nxt_take  = 1'b1;
          end else if (state_ff == TSG_PRE && post_en) begin
            nxt_state = TSG_POST;
            nxt_sel   = post_sym;
          end else nxt_state = TSG_IDLE;
        end
      end
      // After a leading burst go on as after its pattern; a trailing burst ends the frame
      TSG_BURST: begin
        if (bit_end) begin
          if (bit_idx_ff != 8'h00) nxt_idx = bit_idx_ff - 8'h01;
          else if (!burst_post_ff && data_en) begin
            nxt_state = TSG_DATA;
            nxt_take  = 1'b1;
          end else if (!burst_post_ff && post_en) begin
            nxt_state = TSG_POST;
            nxt_sel   = post_sym;
          end else nxt_state = TSG_IDLE;
        end
      end
      TSG_DATA: begin
        if (bit_end) begin
          if (bit_idx_ff != 8'h07) nxt_idx = bit_idx_ff + 8'h01;
          else if (!last_ff) nxt_take = 1'b1;
          else if (post_en) begin
            nxt_state = TSG_POST;
            nxt_sel   = post_sym;
          end else nxt_state = TSG_IDLE;
        end
      end
      default: nxt_state = TSG_IDLE;
    endcase
  end

  // A data byte must be waiting when one is needed; otherwise the frame stalls
  wire stall = nxt_take & ~data_valid;
  assign data_ready = nxt_take & data_valid;

  // Sequencer registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_ff   <= TSG_IDLE;
      sym_sel_ff <= 2'd0;
      bit_idx_ff <= 8'h00;
      div_ff     <= 8'h00;
      byte_ff    <= 8'h00;
      last_ff    <= 1'b0;
      busy_ff    <= 1'b0;
      burst_post_ff <= 1'b0;
    end else if (!stall) begin
      state_ff   <= nxt_state;
      sym_sel_ff <= nxt_sel;
      busy_ff    <= (nxt_state != TSG_IDLE);
      burst_post_ff <= (state_ff == TSG_BURST) ? burst_post_ff : (state_ff == TSG_POST);
      div_ff     <= (bit_end || state_ff == TSG_IDLE) ? 8'h00 : div_ff + 8'h01;
      if (nxt_take) begin
        byte_ff    <= data_byte;
        last_ff    <= data_last;
        bit_idx_ff <= 8'h00;
      end else if (nxt_state != state_ff && nxt_state != TSG_BURST) begin
        bit_idx_ff <= {4'h0, (nxt_sel == 2'd0) ? len0 : (nxt_sel == 2'd1) ? len1 :
                             (nxt_sel == 2'd2) ? len2 : len3};
        last_ff    <= (state_ff == TSG_PRE) ? 1'b0 : last_ff;
      end else begin
        bit_idx_ff <= nxt_idx;
      end
    end
  end

  // Serial output, registered; holds level for a whole bit period
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) tx_bit_ff <= 1'b0;
    else if (busy_ff && div_ff == 8'h00) begin
      unique case (state_ff)
        TSG_DATA:  tx_bit_ff <= data_bit;
        TSG_BURST: tx_bit_ff <= burst_lvl;
        TSG_IDLE:  tx_bit_ff <= 1'b0;
        default:   tx_bit_ff <= pat_bit;
      endcase
    end
  end
  assign tx_bit     = tx_bit_ff;
  assign tx_active  = busy_ff;
  assign tx_bit_stb = busy_ff & (div_ff == 8'h00);
  assign tx_cfg     = cur_cfg;

  // Checks
  chk_short_no_burst: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff == TSG_BURST) |-> !sym_sel_ff[1]) else $error("short symbol bursting");
  chk_pre_choice: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff == TSG_PRE) |-> (sym_sel_ff != 2'd3)) else $error("bad pre symbol");
  chk_post_choice: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff == TSG_POST) |-> (sym_sel_ff != 2'd0)) else $error("bad post symbol");
  chk_short_len_cap: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff == TSG_PRE && sym_sel_ff[1]) |-> bit_idx_ff < 8'h08) else $error("short len");
  chk_pair_cfg: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff == TSG_POST && sym_sel_ff == 2'd3) |-> tx_cfg == short_cfg_ff)
    else $error("wrong pair config");
  chk_bit_period: assert property (@(posedge clock) disable iff (!reset_n)
    (tx_bit_stb && div_max == 8'h01 && !stall)
    |=> !tx_bit_stb ##1 ((tx_bit_stb == tx_active) || $past(stall)))
    else $error("bit period wrong");
  chk_data_gate: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff != TSG_DATA) ##1 (state_ff == TSG_DATA) |-> data_en)
    else $error("data while coding off");
  chk_pattern_out: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff == TSG_PRE && tx_bit_stb) |=> tx_bit == $past(pat_bit))
    else $error("pattern bit wrong");

  // Leading symbol: loaded with its own length, first bit strobed at once
  sequence seq_pre_start;
    (state_ff == TSG_IDLE) && frame_start && pre_en;
  endsequence
  sequence seq_pre_first_bit;
    (state_ff == TSG_PRE) && (bit_idx_ff[3:0] == cur_len) && tx_bit_stb;
  endsequence
  chk_pre_entry: assert property (@(posedge clock) disable iff (!reset_n)
    seq_pre_start |=> seq_pre_first_bit ##0 (sym_sel_ff == $past(pre_sym)))
    else $error("leading symbol start wrong");
  chk_pattern_step: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff inside {TSG_PRE, TSG_POST} && bit_end && bit_idx_ff != 8'h00)
    |=> (state_ff == $past(state_ff)) && (bit_idx_ff == $past(bit_idx_ff) - 8'h01))
    else $error("pattern count wrong");

  // Burst: entered only from a finished long pattern, counted from its own field
  sequence seq_burst_due;
    (state_ff inside {TSG_PRE, TSG_POST}) && bit_end && (bit_idx_ff == 8'h00) && burst_on;
  endsequence
  sequence seq_burst_loaded;
    (state_ff == TSG_BURST) && tx_bit_stb;
  endsequence
  chk_burst_entry: assert property (@(posedge clock) disable iff (!reset_n)
    seq_burst_due |=> seq_burst_loaded ##0 (bit_idx_ff == $past(burst_n)))
    else $error("burst start wrong");
  chk_burst_level: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff == TSG_BURST && tx_bit_stb) |=> (tx_bit == $past(burst_lvl)))
    else $error("burst level wrong");
  chk_short_skip_burst: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff inside {TSG_PRE, TSG_POST} && sym_sel_ff[1] && bit_end && bit_idx_ff == 8'h00)
    |=> (state_ff != TSG_BURST))
    else $error("short symbol burst");
  chk_pre_burst_data: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff == TSG_BURST && !burst_post_ff && bit_end && bit_idx_ff == 8'h00 && data_en)
    |=> (state_ff == TSG_DATA) || ($past(stall) && state_ff == TSG_BURST))
    else $error("data skipped after burst");
  chk_post_burst_ends: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff == TSG_BURST && burst_post_ff && bit_end && bit_idx_ff == 8'h00)
    |=> (state_ff == TSG_IDLE))
    else $error("trailing burst not last");

  // Data bytes: a taken byte starts at bit 0 with no gap, then counts upward
  sequence seq_byte_taken;
    data_ready;
  endsequence
  sequence seq_byte_first_bit;
    (state_ff == TSG_DATA) && (bit_idx_ff == 8'h00) && tx_bit_stb;
  endsequence
  chk_byte_start: assert property (@(posedge clock) disable iff (!reset_n)
    seq_byte_taken |=> seq_byte_first_bit ##0 (byte_ff == $past(data_byte)))
    else $error("byte start wrong");
  chk_data_lsb_first: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff == TSG_DATA && tx_bit_stb && bit_idx_ff == 8'h00)
    |=> (tx_bit == $past(byte_ff[0])))
    else $error("data not lsb first");
  chk_data_step: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff == TSG_DATA && bit_end && bit_idx_ff != 8'h07)
    |=> (bit_idx_ff == $past(bit_idx_ff) + 8'h01))
    else $error("data count wrong");

  // Trailing symbol and the configuration in force
  chk_post_from_field: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff != TSG_POST) ##1 (state_ff == TSG_POST) |-> (sym_sel_ff == post_sym))
    else $error("trailing symbol not from field");
  chk_post_ends: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff == TSG_POST && bit_end && bit_idx_ff == 8'h00 && !burst_on)
    |=> (state_ff == TSG_IDLE) && !tx_active)
    else $error("trailing symbol not last");
  chk_short_cfg_sel: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff inside {TSG_PRE, TSG_POST} && sym_sel_ff[1]) |-> (tx_cfg == short_cfg_ff))
    else $error("short pair config wrong");
  chk_long_cfg_sel: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff == TSG_DATA || (state_ff != TSG_IDLE && !sym_sel_ff[1]))
    |-> (tx_cfg == long_cfg_ff))
    else $error("long pair config wrong");

  // Bit timing: the divider only climbs inside a bit, and idle stays silent
  chk_div_count: assert property (@(posedge clock) disable iff (!reset_n)
    (busy_ff && !bit_end && !stall) |=> (div_ff == $past(div_ff) + 8'h01))
    else $error("bit divider skipped");
  chk_idle_quiet: assert property (@(posedge clock) disable iff (!reset_n)
    (state_ff == TSG_IDLE) |-> (!tx_active && !tx_bit_stb))
    else $error("strobe while idle");

endmodule : tsg_symbol_gen
`default_nettype wire

/* verilog/tsg_defs.svh */
// Functional notes
// - Long symbols carry up to 16-bit patterns and bursts up to 256 constant bits.
// - Short symbols carry at most 8-bit patterns and never a burst.
// - The last bit sent of a symbol is the register's least significant bit.
// - Length completes a definition; bits above the length position are ignored.
// - Pattern sent from bit[length] down to bit 0; length five gives six bits.
// - One length register covers long symbols, another covers short symbols.
// - Only first long, second long or first short symbol may precede data.
// - Only second long, first short or second short symbol may follow data.
// - Symbols around a frame are chosen by frame control fields only.
// - Long pair shares one timing config; short pair shares another.
// - Pair config sets bit clock, subcarrier, pulse type/length and envelope.
// - Frame data bytes are sent least significant bit first.
// - Data coding type zero selects the byte-wise default bit encoder.
//
// Constants of the transmit symbol generator: register offsets, fields, resets.
// Assumes a plain strobed register port on the 40 MHz system clock.
`ifndef TSG_DEFS_SVH
`define TSG_DEFS_SVH
`define TSG_ADDR_W        4
`define TSG_A_SYM0        4'h0
`define TSG_A_SYM1        4'h1
`define TSG_A_SYM2        4'h2
`define TSG_A_SYM3        4'h3
`define TSG_A_LONG_LEN    4'h4
`define TSG_A_SHORT_LEN   4'h5
`define TSG_A_FRAME_CON   4'h6
`define TSG_A_LONG_CFG    4'h7
`define TSG_A_SHORT_CFG   4'h8
`define TSG_A_BURST_LEN   4'h9
`define TSG_A_STATUS      4'ha
// Frame control fields
`define TSG_FC_PRE_LO     0
`define TSG_FC_POST_LO    2
`define TSG_FC_DCODE_LO   4
`define TSG_FC_DCODE_DEF  4'h0
// Pair config fields: [7:0] bit divider, [11:8] subcarrier, [13:12] pulse type,
// [17:14] pulse length, [19:18] envelope
`define TSG_CFG_DIV_W     8
`define TSG_CFG_W         20
// Long length reg: [3:0] sym0 len, [7:4] sym1 len; short: [2:0] sym2, [6:4] sym3
// Burst reg: [7:0] sym0 burst-1, [8] enable, [9] level; [23:16],[24],[25] for sym1
`define TSG_BURST_EN      8
`define TSG_BURST_LVL     9
`define TSG_RST_CFG       20'h00003
`endif

/* verilog/tsg_pkg.sv */
// Types for the transmit symbol generator.
// Assumes tsg_defs.svh supplies all numeric constants.
package tsg_pkg;
  typedef enum logic [2:0] {
    TSG_IDLE  = 3'b000,
    TSG_PRE   = 3'b001,
    TSG_BURST = 3'b010,
    TSG_DATA  = 3'b011,
    TSG_POST  = 3'b100
  } tsg_state_t;
endpackage : tsg_pkg

/* testbench/tsg_modulator_model.sv */
// Modulator stand-in: records each serial bit and the cycles between bit strobes.
// Assumes tx_bit settles the cycle after its tx_bit_stb, as the generator promises.
`timescale 1ns/1ps
`default_nettype none
module tsg_modulator_model (
  input wire logic clock,      // System clock
  input wire logic reset_n,    // Async reset, active low
  input wire logic tx_bit,     // Serial bit from generator
  input wire logic tx_bit_stb  // Pulse at start of each bit
);
  logic stb_q;
  int   gap_cnt;
  logic bit_q[$];
  int   gap_q[$];
  // Take the bit one cycle late so the capture never races its update
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stb_q <= 1'b0;
      gap_cnt <= 0;
    end else begin
      stb_q <= tx_bit_stb;
      gap_cnt <= tx_bit_stb ? 1 : gap_cnt + 1;
      if (tx_bit_stb) gap_q.push_back(gap_cnt);
      if (stb_q) bit_q.push_back(tx_bit);
    end
  end
endmodule : tsg_modulator_model
`default_nettype wire

/* testbench/tsg_symbol_gen_test.sv */
// Testbench of the symbol generator: register port tasks and whole-frame streams.
// Assumes the modulator model captures bits; frame bytes come from a local queue.
`timescale 1ns/1ps
`default_nettype none
`include "tsg_defs.svh"
module tsg_symbol_gen_test;
  logic        clock, reset_n, reg_wr, reg_rd, frame_start;
  logic        data_valid, data_last, data_ready, tx_bit, tx_active, tx_bit_stb;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  logic [7:0]  data_byte;
  logic [19:0] cfg_out;
  logic        exp_b[$];
  int          exp_d[$];
  logic [7:0]  src_q[$];
  int          fails, tests_run;
  tsg_symbol_gen tsg_symbol_gen_inst (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .frame_start(frame_start), .data_valid(data_valid), .data_byte(data_byte),
    .data_last(data_last), .data_ready(data_ready), .tx_bit(tx_bit),
    .tx_active(tx_active), .tx_bit_stb(tx_bit_stb), .tx_cfg(cfg_out));
  tsg_modulator_model tsg_modulator_model_inst (.clock(clock), .reset_n(reset_n),
    .tx_bit(tx_bit), .tx_bit_stb(tx_bit_stb));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Byte source: a byte leaves the queue on the edge that takes it
  always @(posedge clock) begin
    if (data_valid && data_ready) void'(src_q.pop_front());
    data_valid <= src_q.size() != 0;
    data_byte <= (src_q.size() != 0) ? src_q[0] : 8'h00;
    data_last <= src_q.size() == 1;
  end
  task automatic note(input string msg);
    fails++;
    $display("unexpected t=%0t %s", $time, msg);
  endtask : note
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic cmp32(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    tests_run++;
    if (reg_rdata !== e) note($sformatf("read %h got %h want %h", a, reg_rdata, e));
  endtask : cmp32
  // Expected stream: pattern from bit[len] down to bit 0
  task automatic add_pat(input logic [15:0] v, input int len, input int div);
    for (int i = len; i >= 0; i--) begin
      exp_b.push_back(v[i]);
      exp_d.push_back(div);
    end
  endtask : add_pat
  task automatic add_run(input logic lvl, input int n, input int div);
    for (int i = 0; i < n; i++) begin
      exp_b.push_back(lvl);
      exp_d.push_back(div);
    end
  endtask : add_run
  // Frame bytes go out least significant bit first
  task automatic add_byte(input logic [7:0] b, input int div);
    src_q.push_back(b);
    for (int i = 0; i < 8; i++) begin
      exp_b.push_back(b[i]);
      exp_d.push_back(div);
    end
  endtask : add_byte
  // Runs one frame and compares every bit and the period of every bit but the last
  task automatic send(input logic [7:0] fc, input string name);
    int n;
    wr(`TSG_A_FRAME_CON, {24'h000000, fc});
    tsg_modulator_model_inst.bit_q.delete();
    tsg_modulator_model_inst.gap_q.delete();
    @(posedge clock);
    frame_start <= 1'b1;
    @(posedge clock);
    frame_start <= 1'b0;
    n = 0;
    while (tx_active !== 1'b1 && n < 10) begin
      @(posedge clock);
      n++;
    end
    while (tx_active !== 1'b0 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    repeat (4) @(posedge clock);
    tests_run++;
    if (n >= 3000) note("frame never ended");
    if (tsg_modulator_model_inst.bit_q.size() != exp_b.size())
      note($sformatf("%s bit count %0d want %0d", name,
        tsg_modulator_model_inst.bit_q.size(), exp_b.size()));
    else
      for (int i = 0; i < exp_b.size(); i++) begin
        if (tsg_modulator_model_inst.bit_q[i] !== exp_b[i]) note($sformatf("%s bit %0d", name, i));
        if (i > 0 && tsg_modulator_model_inst.gap_q[i] != exp_d[i-1] + 1)
          note($sformatf("%s period before bit %0d", name, i));
      end
    exp_b.delete();
    exp_d.delete();
    $display("test %s done", name);
  endtask : send
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // Watchdog well beyond the longest expected run
  initial begin
    repeat (40000) @(posedge clock);
    note("timeout");
    print_verdict();
  end
  initial begin
    fails = 0; tests_run = 0; reset_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 4'h0; reg_wdata = 32'h0; frame_start = 1'b0; data_valid = 1'b0;
    data_byte = 8'h00; data_last = 1'b0;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    tests_run++;
    if (cfg_out !== `TSG_RST_CFG) note("config after reset");
    cmp32(`TSG_A_LONG_CFG, {12'h000, `TSG_RST_CFG});
    wr(`TSG_A_SYM0, 32'h0000a5c3);
    wr(`TSG_A_SYM1, 32'h00008001);
    wr(`TSG_A_SYM2, 32'h000000ea);
    wr(`TSG_A_SYM3, 32'h00000096);
    wr(`TSG_A_LONG_LEN, 32'h0000000f);
    wr(`TSG_A_SHORT_LEN, 32'h00000075);
    wr(`TSG_A_BURST_LEN, 32'h01ff0302);
    wr(`TSG_A_LONG_CFG, 32'h00000001);
    wr(`TSG_A_SHORT_CFG, 32'h00000002);
    cmp32(`TSG_A_SYM0, 32'h0000a5c3);
    cmp32(4'hb, 32'h00000000);
    $display("test registers done");
    // Full 16-bit pattern, 3-bit burst of ones, two bytes, 8-bit short post
    add_pat(16'ha5c3, 15, 1);
    add_run(1'b1, 3, 1);
    add_byte(8'h3c, 1);
    add_byte(8'h81, 1);
    add_pat(16'h0096, 7, 2);
    send(8'h0d, "long_pre_short_post");
    // One-bit pattern with 256-bit zero burst, no data, short post with masked bits
    add_pat(16'h0001, 0, 1);
    add_run(1'b0, 256, 1);
    add_pat(16'h002a, 5, 2);
    send(8'h1a, "burst_no_data");
    add_pat(16'h002a, 5, 2);
    add_byte(8'h5a, 1);
    add_pat(16'h0001, 0, 1);
    add_run(1'b0, 256, 1);
    send(8'h07, "short_pre_long_post");
    add_byte(8'hc1, 1);
    send(8'h00, "data_only");
    print_verdict();
  end
endmodule : tsg_symbol_gen_test
`default_nettype wire
